// ### hw/cid_top.sv
`timescale 1ns/10ps
// Functional notes
// - FSK output shares the dual-tone pin
// - Transmit FSK at 1200 baud, V.23 or 202
// - Only bit zero of transmit register sent
// - Transmit control gates FSK onto output
// - Recognized alert raises present bit, sets flag
// - Guard timer ticks 0.858 ms, restarts at edge
// - Timer equals present limit: stop, set present
// - Absent timing uses falling edge, absent limit
// - Present bit hardware only; flag software cleared
// - Carrier detect rises after 8 ms energy
// - Carrier detect falls after over 8 ms silence
// - Demodulate 1200 baud bit with bit clock
// - Complete byte loads register, sets ready bit
// - Ready bit rise sets flag; software clears
// - Summary flag is OR of all flags
module cid_top #(
	parameter int BIT_CYC        = cid_pkg::BIT_CYC,
	parameter int GUARD_TICK_CYC = cid_pkg::GUARD_TICK_CYC,
	parameter int CARRIER_CYC    = cid_pkg::CARRIER_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        dual_tone_in,
	input  wire logic        alert_raw_detect,
	input  wire logic        fsk_band_energy,
	input  wire logic        fsk_band_signal,
	output logic             dual_tone_output_pin,
	output logic             irq
);
	localparam logic [15:0] BIT_LAST   = 16'(BIT_CYC - 1);
	localparam logic [15:0] BIT_HALF   = 16'(BIT_CYC / 2);
	localparam logic [15:0] TICK_LAST  = 16'(GUARD_TICK_CYC - 1);
	localparam logic [19:0] CARR_ON    = 20'(CARRIER_CYC);
	localparam logic [19:0] CARR_OFF   = 20'(CARRIER_CYC + 1);
	localparam logic [15:0] SPLIT_HALF = 16'(cid_pkg::DEMOD_SPLIT_HALF);

	typedef enum logic [1:0] {CID_RX_IDLE, CID_RX_START, CID_RX_DATA, CID_RX_STOP} cid_rx_type;
	typedef enum logic [1:0] {CID_GT_IDLE, CID_GT_PRESENT, CID_GT_ABSENT} cid_gt_type;

	function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
		hit = (addr[5:2] == off[5:2]);
	endfunction : hit

	// Pin synchronisers
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic       raw_prev_q;
	logic       sig_prev_q;
	logic       alert_raw_s;
	logic       energy_s;
	logic       signal_s;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {fsk_band_signal, fsk_band_energy, alert_raw_detect};
			sync2_q <= sync1_q;
		end
	end

	assign alert_raw_s = sync2_q[0];
	assign energy_s    = sync2_q[1];
	assign signal_s    = sync2_q[2];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			raw_prev_q <= 1'b0;
			sig_prev_q <= 1'b0;
		end else begin
			raw_prev_q <= alert_raw_s;
			sig_prev_q <= signal_s;
		end
	end

	// Bus slave
	logic                    acc;
	logic                    wr_acc;
	logic                    rd_acc;
	logic [2:0]              ctrl_q;
	logic                    tx_bit_q;
	logic [7:0]              pguard_q;
	logic [7:0]              aguard_q;
	logic [cid_pkg::NUM_FLAGS-1:0] flags_q;
	logic [cid_pkg::NUM_FLAGS-1:0] flag_en_q;
	logic [cid_pkg::NUM_FLAGS-1:0] flag_set;
	logic [cid_pkg::NUM_FLAGS-1:0] flag_clr;
	logic [7:0]              rx_byte_q;
	cid_pkg::cid_status_type status;
	logic [31:0]             rd_mux;

	// One wait state: the answer is registered on the first request cycle
	assign acc    = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_acc = acc & avs_write & avs_byteenable[0];
	assign rd_acc = acc & avs_read;

	always_ff @(posedge clk) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q    <= cid_pkg::CTRL_RST;
			tx_bit_q  <= 1'b1;
			pguard_q  <= cid_pkg::PGUARD_RST;
			aguard_q  <= cid_pkg::AGUARD_RST;
			flag_en_q <= '0;
		end else if (wr_acc) begin
			if (hit(avs_address, cid_pkg::OFF_CTRL))
				ctrl_q <= avs_writedata[2:0];
			if (hit(avs_address, cid_pkg::OFF_TX_BIT))
				tx_bit_q <= avs_writedata[0];
			if (hit(avs_address, cid_pkg::OFF_PGUARD))
				pguard_q <= avs_writedata[7:0];
			if (hit(avs_address, cid_pkg::OFF_AGUARD))
				aguard_q <= avs_writedata[7:0];
			if (hit(avs_address, cid_pkg::OFF_FLAG_EN))
				flag_en_q <= avs_writedata[cid_pkg::NUM_FLAGS-1:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(avs_address, cid_pkg::OFF_CTRL))
			rd_mux[2:0] = ctrl_q;
		else if (hit(avs_address, cid_pkg::OFF_TX_BIT))
			rd_mux[0] = tx_bit_q;
		else if (hit(avs_address, cid_pkg::OFF_PGUARD))
			rd_mux[7:0] = pguard_q;
		else if (hit(avs_address, cid_pkg::OFF_AGUARD))
			rd_mux[7:0] = aguard_q;
		else if (hit(avs_address, cid_pkg::OFF_STATUS))
			rd_mux[5:0] = status;
		else if (hit(avs_address, cid_pkg::OFF_FLAGS))
			rd_mux[cid_pkg::FLAG_SUMMARY:0] = {|flags_q, flags_q};
		else if (hit(avs_address, cid_pkg::OFF_FLAG_EN))
			rd_mux[cid_pkg::NUM_FLAGS-1:0] = flag_en_q;
		else if (hit(avs_address, cid_pkg::OFF_RX_BYTE))
			rd_mux[7:0] = rx_byte_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			avs_readdata <= 32'h0000_0000;
		else if ((avs_read | avs_write) & avs_waitrequest)
			avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
	end

	// Transmitter
	cid_pkg::cid_tx_cfg_type tx_cfg;

	assign tx_cfg = '{enable: ctrl_q[cid_pkg::CTRL_TX_EN],
	                  v23:    ctrl_q[cid_pkg::CTRL_V23],
	                  tx_bit: tx_bit_q};

	cid_fsk_tx #(
		.BIT_CYC (BIT_CYC)
	) u_tx (
		.clk                  (clk),
		.rst_n                (rst_n),
		.cfg                  (tx_cfg),
		.dual_tone_in         (dual_tone_in),
		.dual_tone_output_pin (dual_tone_output_pin)
	);

	// Alert guard timing
	cid_gt_type  gt_q;
	logic [15:0] tick_cnt_q;
	logic        tick;
	logic [7:0]  timer_q;
	logic        alert_present_q;
	logic        alert_prev_q;

	assign tick = (tick_cnt_q >= TICK_LAST);

	// Prescaler restarts with the timer so the first tick is a full period
	always_ff @(posedge clk) begin
		if (!rst_n || (alert_raw_s != raw_prev_q) || tick)
			tick_cnt_q <= 16'h0000;
		else
			tick_cnt_q <= tick_cnt_q + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gt_q            <= CID_GT_IDLE;
			timer_q         <= cid_pkg::TIMER_INIT;
			alert_present_q <= 1'b0;
		end else if (alert_raw_s & ~raw_prev_q) begin
			gt_q    <= CID_GT_PRESENT;
			timer_q <= cid_pkg::TIMER_INIT;
		end else if (~alert_raw_s & raw_prev_q) begin
			gt_q    <= CID_GT_ABSENT;
			timer_q <= cid_pkg::TIMER_INIT;
		end else begin
			unique case (gt_q)
				CID_GT_IDLE: begin
				end
				CID_GT_PRESENT: begin
					if (timer_q == pguard_q) begin
						gt_q            <= CID_GT_IDLE;
						alert_present_q <= 1'b1;
					end else if (tick) begin
						timer_q <= timer_q + 8'h01;
					end
				end
				CID_GT_ABSENT: begin
					if (timer_q == aguard_q) begin
						gt_q            <= CID_GT_IDLE;
						alert_present_q <= 1'b0;
					end else if (tick) begin
						timer_q <= timer_q + 8'h01;
					end
				end
			endcase
		end
	end

	// Carrier detect
	logic [19:0] carr_cnt_q;
	logic        carrier_q;

	// Counts only while energy disagrees with the output, so dropouts restart it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			carr_cnt_q <= 20'h00000;
			carrier_q  <= 1'b0;
		end else if (energy_s == carrier_q) begin
			carr_cnt_q <= 20'h00000;
		end else if (!carrier_q && carr_cnt_q >= CARR_ON - 20'h00001) begin
			carr_cnt_q <= 20'h00000;
			carrier_q  <= 1'b1;
		end else if (carrier_q && carr_cnt_q >= CARR_OFF - 20'h00001) begin
			carr_cnt_q <= 20'h00000;
			carrier_q  <= 1'b0;
		end else begin
			carr_cnt_q <= carr_cnt_q + 20'h00001;
		end
	end

	// Demodulator
	logic [15:0] edge_cnt_q;
	logic        demod_q;
	logic        demod_prev_q;

	// Long half-periods are the lower (mark) tone
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			edge_cnt_q <= 16'h0000;
			demod_q    <= 1'b1;
		end else if (signal_s != sig_prev_q) begin
			edge_cnt_q <= 16'h0000;
			demod_q    <= (edge_cnt_q >= SPLIT_HALF);
		end else if (edge_cnt_q != 16'hffff) begin
			edge_cnt_q <= edge_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			demod_prev_q <= 1'b1;
		else
			demod_prev_q <= demod_q;
	end

	// Byte assembly
	cid_rx_type  rx_q;
	logic [15:0] rx_cnt_q;
	logic [2:0]  rx_idx_q;
	logic [7:0]  shift_q;
	logic        bit_clk_q;
	logic        byte_ready_q;
	logic        byte_prev_q;
	logic        rx_on;

	assign rx_on = ctrl_q[cid_pkg::CTRL_RX_EN] & carrier_q;

	always_ff @(posedge clk) begin
		if (!rst_n || !rx_on) begin
			rx_q      <= CID_RX_IDLE;
			rx_cnt_q  <= 16'h0000;
			rx_idx_q  <= 3'h0;
			shift_q   <= 8'h00;
			bit_clk_q <= 1'b0;
		end else begin
			if (rx_cnt_q == BIT_HALF)
				bit_clk_q <= 1'b0;
			unique case (rx_q)
				CID_RX_IDLE: begin
					if (demod_prev_q & ~demod_q) begin
						rx_q     <= CID_RX_START;
						rx_cnt_q <= BIT_HALF;
					end
				end
				CID_RX_START: begin
					if (rx_cnt_q == 16'h0000) begin
						rx_q     <= demod_q ? CID_RX_IDLE : CID_RX_DATA;
						rx_cnt_q <= BIT_LAST;
						rx_idx_q <= 3'h0;
					end else begin
						rx_cnt_q <= rx_cnt_q - 16'h0001;
					end
				end
				CID_RX_DATA: begin
					if (rx_cnt_q == 16'h0000) begin
						shift_q   <= {demod_q, shift_q[7:1]};
						bit_clk_q <= 1'b1;
						rx_cnt_q  <= BIT_LAST;
						rx_idx_q  <= rx_idx_q + 3'h1;
						if (rx_idx_q == 3'h7)
							rx_q <= CID_RX_STOP;
					end else begin
						rx_cnt_q <= rx_cnt_q - 16'h0001;
					end
				end
				CID_RX_STOP: begin
					if (rx_cnt_q == 16'h0000)
						rx_q <= CID_RX_IDLE;
					else
						rx_cnt_q <= rx_cnt_q - 16'h0001;
				end
			endcase
		end
	end

	// Stop bit must be mark, else the byte is dropped as a framing error
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_byte_q    <= 8'h00;
			byte_ready_q <= 1'b0;
		end else if (rx_on && rx_q == CID_RX_STOP && rx_cnt_q == 16'h0000 && demod_q) begin
			rx_byte_q    <= shift_q;
			byte_ready_q <= 1'b1;
		end else if (rd_acc && hit(avs_address, cid_pkg::OFF_RX_BYTE)) begin
			byte_ready_q <= 1'b0;
		end
	end

	// Flags and interrupt
	assign status = '{alert_raw:            alert_raw_s,
	                  byte_ready_bit:       byte_ready_q,
	                  demod_bit_clock:      bit_clk_q,
	                  demod_serial_bit:     demod_q,
	                  carrier_detect_bit:   carrier_q,
	                  alert_present_status: alert_present_q};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alert_prev_q <= 1'b0;
			byte_prev_q  <= 1'b0;
		end else begin
			alert_prev_q <= alert_present_q;
			byte_prev_q  <= byte_ready_q;
		end
	end

	assign flag_set[cid_pkg::FLAG_ALERT] = alert_present_q & ~alert_prev_q;
	assign flag_set[cid_pkg::FLAG_BYTE]  = byte_ready_q & ~byte_prev_q;
	assign flag_clr = (wr_acc && hit(avs_address, cid_pkg::OFF_FLAG_CLR)) ?
	                  avs_writedata[cid_pkg::NUM_FLAGS-1:0] : '0;

	// A set in the same cycle as a clear wins
	always_ff @(posedge clk) begin
		if (!rst_n)
			flags_q <= '0;
		else
			flags_q <= (flags_q & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(flags_q & flag_en_q);
	end

endmodule : cid_top

// ### hw/cid_pkg.sv
package cid_pkg;

	// Clock and timing figures, each in its own unit
	localparam int CLK_HZ           = 10_000_000;
	localparam int CLK_PERIOD_NS    = 100;
	localparam int FSK_BAUD         = 1200;
	localparam int GUARD_TICK_NS    = 858_000;
	localparam int CARRIER_HOLD_NS  = 8_000_000;
	localparam int B202_SPACE_HZ    = 2200;
	localparam int V23_MARK_HZ      = 1300;
	localparam int V23_SPACE_HZ     = 2100;
	localparam int DEMOD_SPLIT_HZ   = 1700;

	// Derived cycle counts
	localparam int BIT_CYC          = CLK_HZ / FSK_BAUD;
	localparam int GUARD_TICK_CYC   = GUARD_TICK_NS / CLK_PERIOD_NS;
	localparam int CARRIER_CYC      = (CARRIER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int B202_SPACE_HALF  = CLK_HZ / (2 * B202_SPACE_HZ);
	localparam int V23_MARK_HALF    = CLK_HZ / (2 * V23_MARK_HZ);
	localparam int V23_SPACE_HALF   = CLK_HZ / (2 * V23_SPACE_HZ);
	localparam int DEMOD_SPLIT_HALF = CLK_HZ / (2 * DEMOD_SPLIT_HZ);

	// Register byte offsets
	localparam logic [5:0] OFF_CTRL     = 6'h00;
	localparam logic [5:0] OFF_TX_BIT   = 6'h04;
	localparam logic [5:0] OFF_PGUARD   = 6'h08;
	localparam logic [5:0] OFF_AGUARD   = 6'h0c;
	localparam logic [5:0] OFF_STATUS   = 6'h10;
	localparam logic [5:0] OFF_FLAGS    = 6'h14;
	localparam logic [5:0] OFF_FLAG_CLR = 6'h18;
	localparam logic [5:0] OFF_FLAG_EN  = 6'h1c;
	localparam logic [5:0] OFF_RX_BYTE  = 6'h20;

	// Field positions
	localparam int CTRL_TX_EN   = 0;
	localparam int CTRL_V23     = 1;
	localparam int CTRL_RX_EN   = 2;
	localparam int FLAG_ALERT   = 0;
	localparam int FLAG_BYTE    = 1;
	localparam int FLAG_SUMMARY = 2;
	localparam int NUM_FLAGS    = 2;

	// Reset values
	localparam logic [2:0] CTRL_RST   = 3'h0;
	localparam logic [7:0] PGUARD_RST = 8'h00;
	localparam logic [7:0] AGUARD_RST = 8'h00;
	localparam logic [7:0] TIMER_INIT = 8'h00;

	typedef struct packed {
		logic enable;
		logic v23;
		logic tx_bit;
	} cid_tx_cfg_type;

	typedef struct packed {
		logic alert_raw;
		logic byte_ready_bit;
		logic demod_bit_clock;
		logic demod_serial_bit;
		logic carrier_detect_bit;
		logic alert_present_status;
	} cid_status_type;

endpackage : cid_pkg

// ### hw/cid_fsk_tx.sv
`timescale 1ns/10ps
module cid_fsk_tx #(
	parameter int BIT_CYC = cid_pkg::BIT_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire cid_pkg::cid_tx_cfg_type cfg,
	input  wire logic                    dual_tone_in,
	output logic                         dual_tone_output_pin
);
	localparam logic [15:0] BIT_LAST  = 16'(BIT_CYC - 1);
	localparam logic [15:0] B202_MARK = 16'(BIT_CYC / 2);

	logic [15:0] baud_cnt_q;
	logic [15:0] half_cnt_q;
	logic        sym_q;
	logic        tone_q;
	logic [15:0] half_len;

	// Mark is 1; Bell 202 mark tone equals the baud rate
	always_comb begin
		unique case ({cfg.v23, sym_q})
			2'b00:   half_len = 16'(cid_pkg::B202_SPACE_HALF);
			2'b01:   half_len = B202_MARK;
			2'b10:   half_len = 16'(cid_pkg::V23_SPACE_HALF);
			default: half_len = 16'(cid_pkg::V23_MARK_HALF);
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !cfg.enable) begin
			baud_cnt_q <= 16'h0000;
			sym_q      <= 1'b1;
		end else if (baud_cnt_q >= BIT_LAST) begin
			baud_cnt_q <= 16'h0000;
			sym_q      <= cfg.tx_bit;
		end else begin
			baud_cnt_q <= baud_cnt_q + 16'h0001;
		end
	end

	// Phase continues across symbol changes so the tone has no glitch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			half_cnt_q <= 16'h0000;
			tone_q     <= 1'b0;
		end else if (half_cnt_q >= half_len - 16'h0001) begin
			half_cnt_q <= 16'h0000;
			tone_q     <= ~tone_q;
		end else begin
			half_cnt_q <= half_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			dual_tone_output_pin <= 1'b0;
		else
			dual_tone_output_pin <= cfg.enable ? tone_q : dual_tone_in;
	end

endmodule : cid_fsk_tx

// ### dv/cid_chk.sv
`timescale 1ns/10ps
module cid_chk #(
	parameter int BIT_CYC        = 64,
	parameter int GUARD_TICK_CYC = 8,
	parameter int CARRIER_CYC    = 20
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        dual_tone_in,
	input wire logic        dual_tone_output_pin,
	input wire logic        irq
);
	logic [2:0] ctrl_q;
	logic [1:0] en_q;
	logic       wr_ok;
	logic       rd_ok;
	logic [3:0] word;

	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign rd_ok = avs_read && !avs_waitrequest;
	assign word = avs_address[5:2];

	// Shadows of the control and flag enable fields, updated at the completing edge only
	always_ff @(posedge clk) begin
		if (!rst_n)
			ctrl_q <= 3'h0;
		else if (wr_ok && word == cid_pkg::OFF_CTRL[5:2])
			ctrl_q <= avs_writedata[2:0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			en_q <= 2'h0;
		else if (wr_ok && word == cid_pkg::OFF_FLAG_EN[5:2])
			en_q <= avs_writedata[1:0];
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_access;
		(avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	sequence s_fsk_off;
		(!ctrl_q[0] && $stable(dual_tone_in))[*3];
	endsequence

	chk_access_answer: assert property ($rose(avs_read || avs_write) |-> s_access)
		else $error("access not answered in the next cycle");
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_unmapped_zero: assert property (rd_ok && word > 4'h8 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_txbit_bits: assert property (
		rd_ok && word == cid_pkg::OFF_TX_BIT[5:2] |-> avs_readdata[31:1] == 31'h0)
		else $error("transmit bit register holds more than bit zero");
	chk_flag_summary: assert property (
		rd_ok && word == cid_pkg::OFF_FLAGS[5:2] |-> avs_readdata[2] == |avs_readdata[1:0])
		else $error("summary flag is not the OR of the flags");
	chk_ctrl_back: assert property (
		rd_ok && word == cid_pkg::OFF_CTRL[5:2] |-> avs_readdata == {29'h0, ctrl_q})
		else $error("control readback wrong");
	chk_pin_follow: assert property (
		s_fsk_off |-> dual_tone_output_pin == dual_tone_in)
		else $error("pin does not carry dual tone while FSK is off");
	chk_irq_enabled: assert property (irq |-> $past(en_q) != 2'h0)
		else $error("interrupt with every flag masked");
endmodule : cid_chk

bind cid_top cid_chk #(
	.BIT_CYC       (BIT_CYC),
	.GUARD_TICK_CYC(GUARD_TICK_CYC),
	.CARRIER_CYC   (CARRIER_CYC)
) i_chk (
	.clk                 (clk),
	.rst_n               (rst_n),
	.avs_address         (avs_address),
	.avs_read            (avs_read),
	.avs_write           (avs_write),
	.avs_writedata       (avs_writedata),
	.avs_byteenable      (avs_byteenable),
	.avs_readdata        (avs_readdata),
	.avs_waitrequest     (avs_waitrequest),
	.dual_tone_in        (dual_tone_in),
	.dual_tone_output_pin(dual_tone_output_pin),
	.irq                 (irq)
);

// ### dv/cid_front_end.sv
`timescale 1ns/10ps
module cid_front_end (
	input wire logic alert_on,
	input wire logic energy_on,
	output logic     alert_raw_detect,
	output logic     fsk_band_energy,
	output logic     fsk_band_signal
);
	initial begin
		alert_raw_detect = 1'b0;
		fsk_band_energy = 1'b0;
		fsk_band_signal = 1'b0;
	end

	// Detectors settle at moments unrelated to the clock
	always @(alert_on) alert_raw_detect <= #137 alert_on;
	always @(energy_on) fsk_band_energy <= #211 energy_on;

	// Line rests between frames. Slots fit a 3200-cycle bit: the demodulator threshold is fixed,
	// so a mark slot holds one long half that ends just before the receiver's mid-bit sample
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		#37 fsk_band_signal = ~fsk_band_signal;
		#300000;
		for (int i = 0; i < 10; i++) begin
			fsk_band_signal = ~fsk_band_signal;
			if (frame[i]) begin
				#295000 fsk_band_signal = ~fsk_band_signal;
				#25000;
			end else begin
				#150000 fsk_band_signal = ~fsk_band_signal;
				#150000 fsk_band_signal = ~fsk_band_signal;
				#20000;
			end
		end
	endtask : send_byte
endmodule : cid_front_end

// ### dv/cid_top_tb.sv
`timescale 1ns/10ps
module cid_top_tb;
	localparam int BIT_CYC = 3200;
	localparam int CARR    = 20;

	logic        clk;
	logic        rst_n;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        dual_tone_in;
	logic        alert_raw_detect;
	logic        fsk_band_energy;
	logic        fsk_band_signal;
	logic        dual_tone_output_pin;
	logic        irq;
	logic        alert_on;
	logic        energy_on;
	logic [31:0] rd;
	int          mismatches;
	int          checks;

	cid_top #(.BIT_CYC(BIT_CYC), .GUARD_TICK_CYC(8), .CARRIER_CYC(CARR)) i_dut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .dual_tone_in(dual_tone_in),
		.alert_raw_detect(alert_raw_detect), .fsk_band_energy(fsk_band_energy),
		.fsk_band_signal(fsk_band_signal), .dual_tone_output_pin(dual_tone_output_pin),
		.irq(irq));

	cid_front_end i_fe (.alert_on(alert_on), .energy_on(energy_on),
		.alert_raw_detect(alert_raw_detect), .fsk_band_energy(fsk_band_energy),
		.fsk_band_signal(fsk_band_signal));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// One access; an edge always passes before the next request is raised
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rd_chk

	task automatic t_reset_values;
		rd_chk(cid_pkg::OFF_CTRL, 32'h0);
		rd_chk(cid_pkg::OFF_TX_BIT, 32'h1);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h0);
		bus(1'b1, 6'h24, 32'hffff_ffff);
		rd_chk(6'h24, 32'h0);
		bus(1'b1, cid_pkg::OFF_STATUS, 32'hffff_ffff);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd & 32'h23, 32'h0);
	endtask : t_reset_values

	task automatic t_tx_bit;
		bus(1'b1, cid_pkg::OFF_TX_BIT, 32'hffff_fffe);
		rd_chk(cid_pkg::OFF_TX_BIT, 32'h0);
		bus(1'b1, cid_pkg::OFF_TX_BIT, 32'h0000_0003);
		rd_chk(cid_pkg::OFF_TX_BIT, 32'h1);
		avs_byteenable <= 4'he;
		bus(1'b1, cid_pkg::OFF_TX_BIT, 32'h0);
		avs_byteenable <= 4'hf;
		rd_chk(cid_pkg::OFF_TX_BIT, 32'h1);
	endtask : t_tx_bit

	task automatic t_tx_tones;
		int half[4];
		int n;
		logic p;
		half = '{cid_pkg::B202_SPACE_HALF, BIT_CYC / 2,
			cid_pkg::V23_SPACE_HALF, cid_pkg::V23_MARK_HALF};
		dual_tone_in <= 1'b1;
		repeat (4) @(posedge clk);
		check(dual_tone_output_pin, 1'b1);
		dual_tone_in <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, cid_pkg::OFF_CTRL, {30'h0, m[1], 1'b1});
			bus(1'b1, cid_pkg::OFF_TX_BIT, m[0] ? 32'hffff_ff01 : 32'h0000_00fe);
			repeat (BIT_CYC + 8) @(posedge clk);
			p = dual_tone_output_pin;
			n = 0;
			while (dual_tone_output_pin === p && n < 9000) begin
				@(posedge clk);
				n++;
			end
			p = dual_tone_output_pin;
			n = 0;
			while (dual_tone_output_pin === p && n < 9000) begin
				@(posedge clk);
				n++;
			end
			check(n >= half[m] - 1 && n <= half[m] + 1, 1'b1);
		end
		bus(1'b1, cid_pkg::OFF_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		check(dual_tone_output_pin, 1'b0);
	endtask : t_tx_tones

	task automatic t_guard;
		bus(1'b1, cid_pkg::OFF_PGUARD, 32'h3);
		bus(1'b1, cid_pkg::OFF_AGUARD, 32'h2);
		bus(1'b1, cid_pkg::OFF_FLAG_EN, 32'h3);
		alert_on <= 1'b1;
		repeat (12) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[0], 1'b0);
		repeat (30) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[0], 1'b1);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h5);
		check(irq, 1'b1);
		alert_on <= 1'b0;
		repeat (8) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[0], 1'b1);
		repeat (30) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[0], 1'b0);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h5);
		bus(1'b1, cid_pkg::OFF_FLAG_CLR, 32'h1);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h0);
		check(irq, 1'b0);
		bus(1'b1, cid_pkg::OFF_FLAG_EN, 32'h0);
		alert_on <= 1'b1;
		repeat (50) @(posedge clk);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h5);
		check(irq, 1'b0);
		alert_on <= 1'b0;
	endtask : t_guard

	task automatic t_carrier;
		bus(1'b1, cid_pkg::OFF_CTRL, 32'h4);
		energy_on <= 1'b1;
		repeat (CARR / 2) @(posedge clk);
		energy_on <= 1'b0;
		repeat (CARR * 2) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[1], 1'b0);
		energy_on <= 1'b1;
		repeat (CARR + 10) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[1], 1'b1);
		energy_on <= 1'b0;
		repeat (CARR / 2) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[1], 1'b1);
		repeat (CARR * 2) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[1], 1'b0);
	endtask : t_carrier

	task automatic t_receive;
		bus(1'b1, cid_pkg::OFF_FLAG_CLR, 32'h3);
		bus(1'b1, cid_pkg::OFF_FLAG_EN, 32'h2);
		bus(1'b1, cid_pkg::OFF_CTRL, 32'h4);
		energy_on <= 1'b1;
		repeat (CARR + 10) @(posedge clk);
		i_fe.send_byte(8'ha5);
		repeat (4) @(posedge clk);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[4], 1'b1);
		check(rd[2], 1'b1);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h6);
		check(irq, 1'b1);
		rd_chk(cid_pkg::OFF_RX_BYTE, 32'ha5);
		bus(1'b0, cid_pkg::OFF_STATUS, 32'h0);
		check(rd[4], 1'b0);
		bus(1'b1, cid_pkg::OFF_FLAG_CLR, 32'h2);
		rd_chk(cid_pkg::OFF_FLAGS, 32'h0);
		energy_on <= 1'b0;
	endtask : t_receive

	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		test_done();
	end

	initial begin
		mismatches = 0;
		checks = 0;
		rst_n = 1'b0;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		dual_tone_in = 1'b0;
		alert_on = 1'b0;
		energy_on = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_values();
		t_tx_bit();
		t_tx_tones();
		t_guard();
		t_carrier();
		t_receive();
		test_done();
	end
endmodule : cid_top_tb
